// File: logic/wdt_pkg.sv
// Constants, port map and timing counts shared by the watchdog design files.
package wdt_pkg;

  // ********************************************************************
  // Timing
  // ********************************************************************
  localparam int CLK_HZ = 25_000_000;
  localparam int TICK_MS = 500;
  localparam int TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;
  localparam int UNIT_MS = 6000;
  localparam int SHORT_MS = 3000;
  localparam int HOLD_MS = 1000;
  localparam logic [7:0] UNIT_TICKS = 8'(UNIT_MS / TICK_MS);
  localparam logic [7:0] SHORT_TICKS = 8'(SHORT_MS / TICK_MS);
  localparam logic [7:0] HOLD_TICKS = 8'(HOLD_MS / TICK_MS);

  // ********************************************************************
  // Port map
  // ********************************************************************
  localparam logic [9:0] BASE_0 = 10'h220;
  localparam logic [9:0] BASE_1 = 10'h2a0;
  localparam logic [9:0] BASE_2 = 10'h320;
  localparam logic [9:0] BASE_3 = 10'h3a0;
  localparam logic [9:0] FACTOR_OFFSET = 10'h003;
  localparam logic [9:0] ALIAS_LO = 10'h076;
  localparam logic [9:0] ALIAS_HI = 10'h077;

  // ********************************************************************
  // Factor codes and watchdog modes
  // ********************************************************************
  localparam logic [7:0] CMD_DISABLE = 8'h00;
  localparam logic [7:0] CMD_FIRST = 8'h80;
  localparam logic [7:0] CMD_LAST = 8'h87;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_COUNT = 2'b01,
    ST_RESET = 2'b10
  } wdt_mode_t;

endpackage

// File: logic/tick_gen.sv
// Restartable time base that pulses once per tick period.
`timescale 1ns/1ps
module tick_gen #(
  parameter int TICK_CYCLES = wdt_pkg::TICK_CYCLES
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic restart,
  output logic tick
);
  localparam int CW = $clog2(TICK_CYCLES + 1);

  typedef struct packed {
    logic [CW-1:0] count;
    logic tick;
  } tick_state_t;

  tick_state_t cur_ff;
  tick_state_t nxt_cur;

  // Restart aligns the first tick to the write, so periods never run short.
  always_comb begin
    nxt_cur = cur_ff;
    nxt_cur.tick = 1'b0;
    if (restart) begin
      nxt_cur.count = '0;
    end else if (cur_ff.count == CW'(TICK_CYCLES - 1)) begin
      nxt_cur.count = '0;
      nxt_cur.tick = 1'b1;
    end else begin
      nxt_cur.count = cur_ff.count + CW'(1);
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cur_ff <= '0;
    end else begin
      cur_ff <= nxt_cur;
    end
  end

  assign tick = cur_ff.tick;
endmodule

// File: logic/io_watchdog.sv
// Watchdog timer reached through a write-only I/O port byte at base plus FACTOR_OFFSET, also at ALIAS_LO/ALIAS_HI on the two lower bases.
`timescale 1ns/1ps
module io_watchdog #(
  parameter int TICK_CYCLES = wdt_pkg::TICK_CYCLES
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [9:0] io_addr,
  input wire logic [7:0] io_data,
  input wire logic io_wr_n,
  input wire logic [1:0] base_sel,
  output logic timeout_reset_out_n,
  output logic indicator_lamp
);

  // ********************************************************************
  // Helpers
  // ********************************************************************
  // base and alias
  function automatic logic port_hit(input logic [9:0] addr, input logic [1:0] sel);
    logic [9:0] base;
    base = wdt_pkg::BASE_0;
    unique case (sel)
      2'b00: base = wdt_pkg::BASE_0;
      2'b01: base = wdt_pkg::BASE_1;
      2'b10: base = wdt_pkg::BASE_2;
      2'b11: base = wdt_pkg::BASE_3;
    endcase
    port_hit = (addr == base + wdt_pkg::FACTOR_OFFSET) ||
               (!sel[1] && (addr == wdt_pkg::ALIAS_LO || addr == wdt_pkg::ALIAS_HI));
  endfunction

  function automatic logic [7:0] period_ticks(input logic [7:0] f);
    logic [7:0] mult;
    mult = {5'h00, f[2:0]};
    period_ticks = (f[2:0] == 3'h0) ? wdt_pkg::SHORT_TICKS : 8'(mult * wdt_pkg::UNIT_TICKS);
  endfunction

  // ********************************************************************
  // State
  // ********************************************************************
  typedef struct packed {
    logic [1:0] wr_n_sync;
    logic wr_n_last;
    logic [9:0] addr_s1;
    logic [9:0] addr_s2;
    logic [7:0] data_s1;
    logic [7:0] data_s2;
    logic [1:0] sel_s1;
    logic [1:0] sel_s2;
    wdt_pkg::wdt_mode_t mode;
    logic [7:0] limit;
    logic [7:0] elapsed;
    logic [7:0] hold;
    logic lamp;
    logic rst_out_n;
    logic restart;
  } wdt_state_t;

  wdt_state_t cur_ff;
  wdt_state_t nxt_cur;
  logic tick;
  logic wr_rise;
  logic hit;
  logic arm_code;
  logic off_code;

  tick_gen #(
    .TICK_CYCLES(TICK_CYCLES)
  ) u_tick_gen (
    .clk(clk),
    .rst_n(rst_n),
    .restart(nxt_cur.restart),
    .tick(tick)
  );
  // The time base restarts on the same edge as the state update, so no stale tick lands in a fresh period.

  // The write is taken at the end of the strobe, when address and data
  // have settled through their synchronisers; the bus holds them past it.
  assign wr_rise = cur_ff.wr_n_sync[1] && !cur_ff.wr_n_last;
  assign hit = wr_rise && port_hit(cur_ff.addr_s2, cur_ff.sel_s2);
  assign arm_code = cur_ff.data_s2 >= wdt_pkg::CMD_FIRST && cur_ff.data_s2 <= wdt_pkg::CMD_LAST;
  assign off_code = cur_ff.data_s2 == wdt_pkg::CMD_DISABLE;

  // ********************************************************************
  // Next state
  // ********************************************************************
  always_comb begin
    nxt_cur = cur_ff;
    nxt_cur.restart = 1'b0;
    nxt_cur.wr_n_sync = {cur_ff.wr_n_sync[0], io_wr_n};
    nxt_cur.wr_n_last = cur_ff.wr_n_sync[1];
    nxt_cur.addr_s1 = io_addr;
    nxt_cur.addr_s2 = cur_ff.addr_s1;
    nxt_cur.data_s1 = io_data;
    nxt_cur.data_s2 = cur_ff.data_s1;
    nxt_cur.sel_s1 = base_sel;
    nxt_cur.sel_s2 = cur_ff.sel_s1;
    unique case (cur_ff.mode)
      wdt_pkg::ST_IDLE: begin
        nxt_cur.lamp = 1'b0;
        if (hit && arm_code) begin
          nxt_cur.mode = wdt_pkg::ST_COUNT;
          nxt_cur.limit = period_ticks(cur_ff.data_s2);
          nxt_cur.elapsed = 8'h00;
          nxt_cur.restart = 1'b1;
        end
      end
      wdt_pkg::ST_COUNT: begin
        if (hit && off_code) begin
          nxt_cur.mode = wdt_pkg::ST_IDLE;
          nxt_cur.lamp = 1'b0;
        end else if (hit && arm_code) begin
          nxt_cur.limit = period_ticks(cur_ff.data_s2);
          nxt_cur.elapsed = 8'h00;
          nxt_cur.restart = 1'b1;
        end else if (tick) begin
          nxt_cur.lamp = !cur_ff.lamp;
          if (8'(cur_ff.elapsed + 8'h01) >= cur_ff.limit) begin
            nxt_cur.mode = wdt_pkg::ST_RESET;
            nxt_cur.rst_out_n = 1'b0;
            nxt_cur.hold = 8'h00;
            nxt_cur.elapsed = 8'h00;
            nxt_cur.restart = 1'b1;
          end else begin
            nxt_cur.elapsed = 8'(cur_ff.elapsed + 8'h01);
          end
        end
      end
      wdt_pkg::ST_RESET: begin
        // Writes during the pulse are dropped: the host is being reset anyway.
        // hold then disable
        if (tick) begin
          if (8'(cur_ff.hold + 8'h01) >= wdt_pkg::HOLD_TICKS) begin
            nxt_cur.mode = wdt_pkg::ST_IDLE;
            nxt_cur.rst_out_n = 1'b1;
            nxt_cur.lamp = 1'b0;
          end else begin
            nxt_cur.hold = 8'(cur_ff.hold + 8'h01);
          end
        end
      end
      default: begin
        nxt_cur.mode = wdt_pkg::ST_IDLE;
        nxt_cur.rst_out_n = 1'b1;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cur_ff <= '{wr_n_sync: 2'b11, wr_n_last: 1'b1, addr_s1: 10'h000, addr_s2: 10'h000,
                 data_s1: 8'h00, data_s2: 8'h00, sel_s1: 2'b00, sel_s2: 2'b00,
                 mode: wdt_pkg::ST_IDLE, limit: 8'h00, elapsed: 8'h00, hold: 8'h00,
                 lamp: 1'b0, rst_out_n: 1'b1, restart: 1'b0};
    end else begin
      cur_ff <= nxt_cur;
    end
  end

  assign timeout_reset_out_n = cur_ff.rst_out_n;
  assign indicator_lamp = cur_ff.lamp;

  // ********************************************************************
  // Checks
  // ********************************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  AST_IDLE_AFTER_RESET: assert property (disable iff (1'b0)
    !rst_n |=> (cur_ff.mode == wdt_pkg::ST_IDLE && timeout_reset_out_n && !indicator_lamp))
    else $error("Watchdog not idle after reset.");
  AST_ARM: assert property (
    (cur_ff.mode == wdt_pkg::ST_IDLE && hit && arm_code) |=>
    (cur_ff.mode == wdt_pkg::ST_COUNT && cur_ff.elapsed == 8'h00 && cur_ff.restart))
    else $error("Valid factor write did not arm the watchdog.");
  AST_PERIOD: assert property (
    (hit && arm_code && cur_ff.mode != wdt_pkg::ST_RESET) |=>
    cur_ff.limit == period_ticks($past(cur_ff.data_s2)))
    else $error("Period does not match the factor written.");
  AST_UNITS: assert property (
    cur_ff.mode == wdt_pkg::ST_COUNT |->
    (cur_ff.limit == wdt_pkg::SHORT_TICKS || (cur_ff.limit % wdt_pkg::UNIT_TICKS == 8'h00 &&
     cur_ff.limit >= wdt_pkg::UNIT_TICKS && cur_ff.limit <= 8'(7 * wdt_pkg::UNIT_TICKS))))
    else $error("Period is not a whole number of units.");
  AST_RETRIGGER: assert property (
    (cur_ff.mode == wdt_pkg::ST_COUNT && hit && arm_code) |=>
    (cur_ff.elapsed == 8'h00 && cur_ff.mode == wdt_pkg::ST_COUNT) ##1 !tick)
    else $error("Retrigger did not clear the count.");
  AST_TIMEOUT: assert property (
    (cur_ff.mode == wdt_pkg::ST_COUNT && !hit && tick && 8'(cur_ff.elapsed + 8'h01) >= cur_ff.limit) |=>
    (!timeout_reset_out_n && cur_ff.mode == wdt_pkg::ST_RESET))
    else $error("Timeout did not assert the reset output.");
  AST_DISABLE: assert property (
    (cur_ff.mode == wdt_pkg::ST_COUNT && hit && off_code) |=>
    (cur_ff.mode == wdt_pkg::ST_IDLE && timeout_reset_out_n)[*2])
    else $error("Disable write did not stop the watchdog.");
  AST_LAMP: assert property (
    (cur_ff.mode == wdt_pkg::ST_COUNT && !hit && tick) |=> indicator_lamp != $past(indicator_lamp))
    else $error("Lamp did not toggle on a tick.");
  AST_LOW_ONLY_IN_PULSE: assert property (
    !timeout_reset_out_n |-> cur_ff.mode == wdt_pkg::ST_RESET)
    else $error("Reset output low outside the timeout pulse.");
  AST_ALIAS: assert property (
    (hit && cur_ff.sel_s2[1]) |-> cur_ff.addr_s2[9:8] == 2'b11)
    else $error("Alias decoded on an upper base setting.");
  AST_HOLD_END: assert property (
    (cur_ff.mode == wdt_pkg::ST_RESET && tick && 8'(cur_ff.hold + 8'h01) >= wdt_pkg::HOLD_TICKS) |=>
    (timeout_reset_out_n && cur_ff.mode == wdt_pkg::ST_IDLE))
    else $error("Reset pulse did not end after the hold time.");
  AST_IGNORE: assert property (
    (cur_ff.mode == wdt_pkg::ST_COUNT && hit && !arm_code && !off_code && !tick) |=>
    ($stable(cur_ff.limit) && $stable(cur_ff.elapsed) && cur_ff.mode == wdt_pkg::ST_COUNT))
    else $error("Invalid code changed the watchdog.");

  COV_ARM: cover property (cur_ff.mode == wdt_pkg::ST_IDLE && hit && arm_code);
  COV_RETRIGGER: cover property (cur_ff.mode == wdt_pkg::ST_COUNT && hit && arm_code);
  COV_TIMEOUT: cover property ($fell(timeout_reset_out_n));
  COV_DISABLE: cover property (cur_ff.mode == wdt_pkg::ST_COUNT && hit && off_code);

endmodule

// File: testbench/io_host_model.sv
// Host bus model that issues single byte port writes to the watchdog.
`timescale 1ns/1ps
module io_host_model (
  input wire logic clk,
  output logic [9:0] io_addr,
  output logic [7:0] io_data,
  output logic io_wr_n,
  output logic [1:0] base_sel
);
  initial begin
    io_addr = 10'h000;
    io_data = 8'h00;
    io_wr_n = 1'b1;
    base_sel = 2'h0;
  end
  // switch setting, allowed to settle before use.
  task automatic sel(input logic [1:0] s);
    base_sel = s;
    repeat (3) @(posedge clk);
    #1;
  endtask
  // one byte per strobe, held across the strobe's rising edge.
  task automatic wr(input logic [9:0] a, input logic [7:0] d);
    io_addr = a;
    io_data = d;
    io_wr_n = 1'b0;
    repeat (4) @(posedge clk);
    #1 io_wr_n = 1'b1;
    repeat (2) @(posedge clk);
    // A released bus floats, so show the inverse rather than a stale value.
    #1 io_addr = ~a;
    io_data = ~d;
    repeat (2) @(posedge clk);
    #1;
  endtask
endmodule

// File: testbench/tb_io_watchdog.sv
// Self-checking bench for the I/O port watchdog.
`timescale 1ns/1ps
module tb_io_port_watchdog_timer;
  localparam int T = 20;
  localparam int H = int'(wdt_pkg::HOLD_TICKS) * T;
  logic clk;
  logic rst_n;
  logic [9:0] io_addr;
  logic [7:0] io_data;
  logic io_wr_n;
  logic [1:0] base_sel;
  logic timeout_reset_out_n;
  logic indicator_lamp;
  logic lamp;
  logic hit;
  logic [9:0] a;
  int miscompares = 0;
  int check_count = 0;
  int n;
  logic [9:0] bases [4] = '{wdt_pkg::BASE_0, wdt_pkg::BASE_1, wdt_pkg::BASE_2, wdt_pkg::BASE_3};
  io_host_model u_io_host_model (.clk(clk), .io_addr(io_addr), .io_data(io_data), .io_wr_n(io_wr_n),
    .base_sel(base_sel));
  io_watchdog #(.TICK_CYCLES(T)) u_io_watchdog (.clk(clk), .rst_n(rst_n), .io_addr(io_addr),
    .io_data(io_data), .io_wr_n(io_wr_n), .base_sel(base_sel),
    .timeout_reset_out_n(timeout_reset_out_n), .indicator_lamp(indicator_lamp));
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  task automatic cyc(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic rng(input int got, input int lo, input int hi);
    check_count++;
    if (got < lo || got > hi) begin
      miscompares++;
      $display("ERROR %0t got %h exp %h to %h", $time, got, lo, hi);
    end
  endtask
  task automatic wt(input logic v, input int lim, output int c);
    c = 0;
    while (timeout_reset_out_n !== v && c < lim) begin
      cyc(1);
      c++;
    end
  endtask
  function automatic int per(input logic [7:0] f);
    if (f == wdt_pkg::CMD_FIRST) begin
      return int'(wdt_pkg::SHORT_TICKS) * T;
    end
    return int'(wdt_pkg::UNIT_TICKS) * int'(f[2:0]) * T;
  endfunction
  // Timeout pulse seen, then its hold, then idle with the lamp dark.
  task automatic expire(input int exp);
    wt(1'b0, 2000, n);
    rng(n, exp - 8, exp + T + 4);
    wt(1'b1, 200, n);
    rng(n, H - 8, H + 8);
    chk(32'(indicator_lamp), 32'h0000_0000);
  endtask
  task automatic print_verdict;
    if (miscompares == 0 && check_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  initial begin
    #1600000;
    miscompares++;
    print_verdict();
  end
  initial begin
    rst_n = 1'b0;
    cyc(10);
    rst_n = 1'b1;
    cyc(3);
    wt(1'b0, 200, n);
    chk(32'(n), 32'h0000_00c8);
    chk(32'(indicator_lamp), 32'h0000_0000);
    // port and alias decode for every switch setting.
    for (int s = 0; s < 4; s++) begin
      for (int k = 0; k < 4; k++) begin
        u_io_host_model.sel(2'(s));
        a = (k == 0) ? bases[s] + wdt_pkg::FACTOR_OFFSET : (k == 3) ? bases[s] : 10'h075 + 10'(k);
        hit = (k == 0) || (k < 3 && s < 2);
        u_io_host_model.wr(a, 8'h80);
        if (hit) begin
          expire(per(8'h80));
        end else begin
          wt(1'b0, 200, n);
          chk(32'(n), 32'h0000_00c8);
        end
      end
    end
    u_io_host_model.sel(2'h0);
    a = wdt_pkg::BASE_0 + wdt_pkg::FACTOR_OFFSET;
    // every factor code gives its own period.
    for (int i = 0; i < 8; i++) begin
      u_io_host_model.wr(a, 8'h80 + 8'(i));
      expire(per(8'h80 + 8'(i)));
    end
    // rewrites inside the period hold the timeout off.
    u_io_host_model.wr(a, 8'h80);
    for (int i = 0; i < 4; i++) begin
      cyc(80);
      chk(32'(timeout_reset_out_n), 32'h0000_0001);
      u_io_host_model.wr(a, 8'h80);
    end
    expire(per(8'h80));
    u_io_host_model.wr(a, 8'h87);
    cyc(100);
    u_io_host_model.wr(a, 8'h80);
    expire(per(8'h80));
    // bad factors neither retrigger nor arm.
    u_io_host_model.wr(a, 8'h80);
    cyc(40);
    u_io_host_model.wr(a, 8'h88);
    u_io_host_model.wr(a, 8'h7f);
    expire(per(8'h80) - 56);
    u_io_host_model.wr(a, 8'h88);
    wt(1'b0, 300, n);
    chk(32'(n), 32'h0000_012c);
    // lamp blinks while counting, disable stops all.
    u_io_host_model.wr(a, 8'h81);
    lamp = indicator_lamp;
    cyc(T + 4);
    chk(32'(indicator_lamp), 32'(!lamp));
    u_io_host_model.wr(a, 8'h00);
    chk(32'(indicator_lamp), 32'h0000_0000);
    wt(1'b0, 400, n);
    chk(32'(n), 32'h0000_0190);
    // a reset in mid-count leaves the watchdog disabled.
    u_io_host_model.wr(a, 8'h80);
    cyc(20);
    rst_n = 1'b0;
    cyc(2);
    rst_n = 1'b1;
    wt(1'b0, 300, n);
    chk(32'(n), 32'h0000_012c);
    print_verdict();
  end
endmodule
